// ==== common/ctx_defs.svh ====
`ifndef CTX_DEFS_SVH
`define CTX_DEFS_SVH

// Register byte offsets
`define CTX_REG_CTRL       8'h00
`define CTX_REG_STATUS     8'h04
`define CTX_REG_CFG        8'h08
`define CTX_REG_WIDTH      8'h0C
`define CTX_REG_FRAMES     8'h10

// Control register fields and reset value
`define CTX_CTRL_CONT_BIT  0
`define CTX_CTRL_EN_BIT    1
`define CTX_CTRL_RST       2'h2

// Status fields: sticky flags and live sleep state
`define CTX_ST_BADTYPE_BIT 0
`define CTX_ST_OVFL_BIT    1
`define CTX_ST_CONFL_BIT   2
`define CTX_ST_SLEEP_LSB   8

// Lane-count select codes
`define CTX_LANES_1        2'h0
`define CTX_LANES_2        2'h1
`define CTX_LANES_4        2'h3

// Short packet data types
`define CTX_DT_FS          6'h00
`define CTX_DT_FE          6'h01
`define CTX_DT_LS          6'h02
`define CTX_DT_LE          6'h03

// AXI responses
`define CTX_RESP_OKAY      2'h0
`define CTX_RESP_DECERR    2'h3

// Sleep request least pulse width
`define CTX_SLEEP_MIN_NS   5000
`define CTX_MCLK_PERIOD_NS 10
`define CTX_SLEEP_CYC      ((`CTX_SLEEP_MIN_NS + `CTX_MCLK_PERIOD_NS - 1) / `CTX_MCLK_PERIOD_NS)

`endif

// ==== common/ctx_pkg.sv ====
package ctx_pkg;

  // Packet header: virtual channel, data type, word count
  typedef struct packed {
    logic [1:0]  vc;
    logic [5:0]  dt;
    logic [15:0] wc;
  } ctx_hdr_t;

  // Word handed from pixel side to link side
  typedef struct packed {
    logic        hdr;
    logic [63:0] data;
  } ctx_word_t;

  // Link serialiser states
  typedef enum logic [0:0] {
    CTX_L_IDLE,
    CTX_L_SEND
  } ctx_lk_state_t;

endpackage : ctx_pkg

// ==== verilog/ctx_pixel_if.sv ====
// Added by the designer: the AXI4-Lite register port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "ctx_defs.svh"

module ctx_pixel_if
  import ctx_pkg::*;
#(
  parameter bit USE_RESETS = 1'b1, // Both reset pins wired (1) or neither (0)
  parameter int AXI_AW     = 8     // AXI address width
) (
  input  wire logic              mclk,
  input  wire logic              rst,
  input  wire logic              shared_tx_pll_ref_pin,
  input  wire logic              phy_reset_n,
  input  wire logic              controller_reset_n,
  input  wire logic [1:0]        lane_select,
  input  wire logic              frame_mode,
  input  wire logic              vsync,
  input  wire logic              hsync,
  input  wire logic              pix_valid,
  input  wire logic [15:0]       line_width,
  input  wire logic [5:0]        data_type,
  input  wire logic [1:0]        virtual_channel,
  input  wire logic [63:0]       pixel_data,
  input  wire logic              clock_lane_sleep_enter,
  input  wire logic              clock_lane_sleep_exit,
  input  wire logic [3:0]        data_lane_sleep_enter,
  input  wire logic [3:0]        data_lane_sleep_exit,
  input  wire logic [AXI_AW-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [AXI_AW-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic [31:0]            lane_data,
  output logic [3:0]             lane_hs_en,
  output logic                   lane_hdr,
  output logic                   clk_lane_hs,
  output logic [3:0]             lane_sleep,
  output logic                   clk_lane_sleep
);

  localparam int SLEEP_CYC = `CTX_SLEEP_CYC; // Least sleep request length in cycles

  // Elaboration checks
  if (AXI_AW < 5) begin : g_bad_aw
    $error("AXI address width too small for the register map");
  end
  if (SLEEP_CYC >= 1024) begin : g_bad_sleep
    $error("Sleep counter too narrow");
  end

  // Lanes carried per select code
  function automatic logic [3:0] lane_mask(input logic [1:0] sel);
    if (sel == `CTX_LANES_4) return 4'hF;
    else if (sel == `CTX_LANES_2) return 4'h3;
    else return 4'h1;
  endfunction : lane_mask

  // Link cycles per 64-bit word, minus one
  function automatic logic [2:0] beats(input logic [1:0] sel);
    if (sel == `CTX_LANES_4) return 3'h1;
    else if (sel == `CTX_LANES_2) return 3'h3;
    else return 3'h7;
  endfunction : beats

  // Bits moved per link cycle across the enabled lanes
  function automatic logic [5:0] lane_bits(input logic [1:0] sel);
    if (sel == `CTX_LANES_4) return 6'h20;
    else if (sel == `CTX_LANES_2) return 6'h10;
    else return 6'h08;
  endfunction : lane_bits

  // Supported video data types
  function automatic logic dt_ok(input logic [5:0] dt);
    return (dt >= 6'h18 && dt <= 6'h1F) || (dt >= 6'h20 && dt <= 6'h24) ||
           (dt >= 6'h28 && dt <= 6'h2D) || (dt >= 6'h30 && dt <= 6'h37);
  endfunction : dt_ok

  // Register index from byte address, 7 when unmapped
  function automatic logic [2:0] reg_index(input logic [AXI_AW-1:0] a);
    if (a == AXI_AW'(`CTX_REG_CTRL)) return 3'h0;
    else if (a == AXI_AW'(`CTX_REG_STATUS)) return 3'h1;
    else if (a == AXI_AW'(`CTX_REG_CFG)) return 3'h2;
    else if (a == AXI_AW'(`CTX_REG_WIDTH)) return 3'h3;
    else if (a == AXI_AW'(`CTX_REG_FRAMES)) return 3'h4;
    else return 3'h7;
  endfunction : reg_index

  // ---------------- Pixel clock domain ----------------
  logic [2:0]  cr_s_q;    // Controller reset pin synchroniser
  logic        cr_lvl_q;  // Agreed controller reset level
  logic        ctrl_rst;  // Packetizer reset
  logic [1:0]  lanes_q;   // Latched lane select
  logic        fm_q;      // Latched frame mode
  logic        vs_q;      // Previous vertical sync
  logic        hs_q;      // Previous horizontal sync
  logic        hl_q;      // Long header pending in accurate mode
  logic [15:0] width_q;   // Line width of current frame
  logic [1:0]  vc_q;      // Virtual channel of current frame
  logic [5:0]  dt_q;      // Data type of current line
  logic [15:0] frames_q;  // Frame start count
  logic [1:0]  ctrl_q;    // Control register
  logic [2:0]  st_q;      // Sticky status
  logic [2:0]  st_clr;    // Status write-one-to-clear
  logic [2:0]  st_set;    // Status events
  ctx_word_t   xw_q;      // Word offered to link side
  ctx_word_t   nw;        // Candidate word
  logic        cand;      // A word wants to go
  logic        launch;    // Word handed over this cycle
  logic        req_q;     // Handover request toggle
  logic [2:0]  ak_s_q;    // Acknowledge synchroniser
  logic        pack_q;    // Agreed acknowledge toggle
  logic        lack_q;    // Acknowledge toggle, driven by the link side
  logic        busy;      // Link still owns previous word
  logic [4:0]  sleep_q;   // Sleep state, bit 4 is clock lane
  logic [9:0]  en_cnt_q [5]; // Enter request run length
  logic [9:0]  ex_cnt_q [5]; // Exit request run length
  logic [4:0]  sl_en;     // Enter requests, clock lane on top
  logic [4:0]  sl_ex;     // Exit requests, clock lane on top

  assign ctrl_rst = rst | (USE_RESETS & cr_lvl_q);
  assign busy     = req_q ^ pack_q;
  assign sl_en    = {clock_lane_sleep_enter, data_lane_sleep_enter};
  assign sl_ex    = {clock_lane_sleep_exit, data_lane_sleep_exit};

  // Controller reset pin: change counts once stages two and three agree
  always_ff @(posedge mclk) begin
    cr_s_q <= {cr_s_q[1:0], ~controller_reset_n};
    if (rst) begin
      cr_lvl_q <= 1'b1;
    end else if (cr_s_q[1] == cr_s_q[2]) begin
      cr_lvl_q <= cr_s_q[2];
    end
  end

  // Static configuration follows its pins only while held in reset
  always_ff @(posedge mclk) begin
    if (ctrl_rst) begin
      lanes_q <= lane_select;
      fm_q    <= frame_mode;
    end
  end

  // Frame and line parameters captured at sync rises
  always_ff @(posedge mclk) begin
    if (ctrl_rst) begin
      vs_q     <= 1'b0;
      hs_q     <= 1'b0;
      hl_q     <= 1'b0;
      width_q  <= 16'h0000;
      vc_q     <= 2'h0;
      dt_q     <= 6'h00;
      frames_q <= 16'h0000;
    end else begin
      vs_q <= vsync;
      hs_q <= hsync;
      hl_q <= hsync & ~hs_q & fm_q;
      if (vsync && !vs_q) begin
        width_q  <= line_width;
        vc_q     <= virtual_channel;
        frames_q <= frames_q + 16'h0001;
      end
      if (hsync && !hs_q) begin
        dt_q <= data_type;
      end
    end
  end

  // Pick one word per cycle: frame, line, then payload
  always_comb begin
    cand = 1'b1;
    nw   = '0;
    if (vsync && !vs_q) begin
      nw.hdr  = 1'b1;
      nw.data = {40'h0, ctx_hdr_t'{virtual_channel, `CTX_DT_FS, frames_q + 16'h0001}};
    end else if (!vsync && vs_q) begin
      nw.hdr  = 1'b1;
      nw.data = {40'h0, ctx_hdr_t'{vc_q, `CTX_DT_FE, frames_q}};
    end else if (hsync && !hs_q) begin
      nw.hdr  = 1'b1;
      if (fm_q) begin
        nw.data = {40'h0, ctx_hdr_t'{vc_q, `CTX_DT_LS, 16'h0000}};
      end else begin
        nw.data = {40'h0, ctx_hdr_t'{vc_q, data_type, width_q}};
      end
    end else if (hl_q) begin
      nw.hdr  = 1'b1;
      nw.data = {40'h0, ctx_hdr_t'{vc_q, dt_q, width_q}};
    end else if (!hsync && hs_q && fm_q) begin
      nw.hdr  = 1'b1;
      nw.data = {40'h0, ctx_hdr_t'{vc_q, `CTX_DT_LE, 16'h0000}};
    end else if (pix_valid) begin
      nw.data = pixel_data;
    end else begin
      cand = 1'b0;
    end
  end

  assign launch = cand & ~busy & ctrl_q[`CTX_CTRL_EN_BIT] & ~ctrl_rst;

  // Handover register and request toggle to the link side
  always_ff @(posedge mclk) begin
    if (rst) begin
      req_q <= 1'b0;
      xw_q  <= '0;
    end else if (launch) begin
      req_q <= ~req_q;
      xw_q  <= nw;
    end
  end

  // Acknowledge toggle back from the link side
  always_ff @(posedge mclk) begin
    ak_s_q <= {ak_s_q[1:0], lack_q};
    if (rst) begin
      pack_q <= 1'b0; // Matches the cleared request toggle
    end else if (ak_s_q[1] == ak_s_q[2]) begin
      pack_q <= ak_s_q[2];
    end
  end

  // Sleep request qualification, one counter pair per lane
  for (genvar g = 0; g < 5; g++) begin : g_sleep
    always_ff @(posedge mclk) begin
      if (ctrl_rst) begin
        en_cnt_q[g] <= 10'h000;
        ex_cnt_q[g] <= 10'h000;
        sleep_q[g]  <= 1'b0;
      end else begin
        en_cnt_q[g] <= (sl_en[g] && !sl_ex[g] && en_cnt_q[g] < 10'(SLEEP_CYC)) ?
                       en_cnt_q[g] + 10'h001 : (sl_en[g] && !sl_ex[g] ? en_cnt_q[g] : 10'h000);
        ex_cnt_q[g] <= (sl_ex[g] && !sl_en[g] && ex_cnt_q[g] < 10'(SLEEP_CYC)) ?
                       ex_cnt_q[g] + 10'h001 : (sl_ex[g] && !sl_en[g] ? ex_cnt_q[g] : 10'h000);
        if (sl_en[g] && !sl_ex[g] && en_cnt_q[g] == 10'(SLEEP_CYC - 1)) begin
          sleep_q[g] <= 1'b1;
        end else if (sl_ex[g] && !sl_en[g] && ex_cnt_q[g] == 10'(SLEEP_CYC - 1)) begin
          sleep_q[g] <= 1'b0;
        end
      end
    end
  end

  // Status events: bad type, dropped word, conflicting sleep requests
  assign st_set[`CTX_ST_BADTYPE_BIT] = ~ctrl_rst & hsync & ~hs_q & ~dt_ok(data_type);
  assign st_set[`CTX_ST_OVFL_BIT]    = ~ctrl_rst & cand & busy & ctrl_q[`CTX_CTRL_EN_BIT];
  assign st_set[`CTX_ST_CONFL_BIT]   = ~ctrl_rst & |(sl_en & sl_ex);

  // ---------------- AXI4-Lite slave ----------------
  logic              aw_hold_q; // Write address held
  logic              w_hold_q;  // Write data held
  logic [AXI_AW-1:0] awaddr_q;  // Held write address
  logic [31:0]       wdata_q;   // Held write data
  logic [3:0]        wstrb_q;   // Held byte strobes
  logic              do_wr;     // Write performed this cycle
  logic [31:0]       rd_word;   // Read mux

  assign s_axi_awready = ~aw_hold_q;
  assign s_axi_wready  = ~w_hold_q;
  assign s_axi_arready = ~s_axi_rvalid;
  assign do_wr         = aw_hold_q & w_hold_q & ~s_axi_bvalid;
  assign st_clr        = (do_wr && reg_index(awaddr_q) == 3'h1 && wstrb_q[0]) ?
                         wdata_q[2:0] : 3'h0;

  // Address and data taken in either order, answered once both held
  always_ff @(posedge mclk) begin
    if (rst) begin
      aw_hold_q    <= 1'b0;
      w_hold_q     <= 1'b0;
      awaddr_q     <= '0;
      wdata_q      <= 32'h0000_0000;
      wstrb_q      <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `CTX_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !aw_hold_q) begin
        aw_hold_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_hold_q) begin
        w_hold_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_hold_q    <= 1'b0;
        w_hold_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (reg_index(awaddr_q) == 3'h7) ? `CTX_RESP_DECERR : `CTX_RESP_OKAY;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Control register and sticky status, set beats clear
  always_ff @(posedge mclk) begin
    if (rst) begin
      ctrl_q <= `CTX_CTRL_RST;
      st_q   <= 3'h0;
    end else begin
      if (do_wr && reg_index(awaddr_q) == 3'h0 && wstrb_q[0]) begin
        ctrl_q <= wdata_q[1:0];
      end
      st_q <= (st_q & ~st_clr) | st_set;
    end
  end

  // Read mux
  always_comb begin
    rd_word = 32'h0000_0000;
    case (reg_index(s_axi_araddr))
      3'h0:    rd_word = {30'h0, ctrl_q};
      3'h1:    rd_word = {19'h0, sleep_q, 5'h00, st_q};
      3'h2:    rd_word = {17'h0, dt_q, 1'b0, vc_q, 3'h0, fm_q, lanes_q};
      3'h3:    rd_word = {16'h0, width_q};
      3'h4:    rd_word = {16'h0, frames_q};
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // Read answer one cycle after the address is taken
  always_ff @(posedge mclk) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `CTX_RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= (reg_index(s_axi_araddr) == 3'h7) ? `CTX_RESP_DECERR : `CTX_RESP_OKAY;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ---------------- Link clock domain ----------------
  logic [8:0]    lv_s1_q, lv_s2_q, lv_s3_q; // Level synchroniser stages
  logic [8:0]    lk_lv_q;   // Agreed levels {sleep, cont, lanes, hard reset}
  logic [2:0]    ph_s_q;    // PHY reset pin synchroniser
  logic          ph_lvl_q;  // Agreed PHY reset level
  logic          lrst;      // Link logic reset
  logic [2:0]    rq_s_q;    // Request toggle synchroniser
  logic          lreq_q;    // Request toggle seen
  logic          lk_new;    // New word arrived
  ctx_lk_state_t lk_st_q;   // Serialiser state
  logic [63:0]   sh_q;      // Word being shifted out
  logic          lhdr_q;    // Word is a header
  logic [2:0]    left_q;    // Beats left
  logic [31:0]   lane_data_q;
  logic [3:0]    lane_hs_en_q;
  logic          lane_hdr_q;
  logic          clk_hs_q;
  logic [3:0]    lk_mask;   // Lanes in use on the link side

  assign lrst   = lk_lv_q[0] | (USE_RESETS & ph_lvl_q);
  assign lk_new = (rq_s_q[1] == rq_s_q[2]) & (rq_s_q[2] != lreq_q);
  assign lk_mask = lane_mask(lk_lv_q[2:1]);

  // Pixel-side levels and PHY reset pin cross into the link domain
  always_ff @(posedge shared_tx_pll_ref_pin) begin
    lv_s1_q  <= {sleep_q, ctrl_q[`CTX_CTRL_CONT_BIT], lanes_q, rst};
    lv_s2_q  <= lv_s1_q;
    lv_s3_q  <= lv_s2_q;
    lk_lv_q  <= (lv_s2_q & lv_s3_q) | (lk_lv_q & (lv_s2_q ^ lv_s3_q));
    ph_s_q   <= {ph_s_q[1:0], ~phy_reset_n};
    ph_lvl_q <= (ph_s_q[1] & ph_s_q[2]) | (ph_lvl_q & (ph_s_q[1] ^ ph_s_q[2]));
    rq_s_q   <= {rq_s_q[1:0], req_q};
  end

  // Serialiser: each word spread over the enabled lanes
  always_ff @(posedge shared_tx_pll_ref_pin) begin
    if (lrst) begin
      lk_st_q <= CTX_L_IDLE;
      lreq_q  <= rq_s_q[2];
      lack_q  <= rq_s_q[2];
      sh_q    <= 64'h0;
      lhdr_q  <= 1'b0;
      left_q  <= 3'h0;
    end else begin
      case (lk_st_q)
        CTX_L_IDLE: begin
          if (lk_new) begin
            lreq_q  <= rq_s_q[2];
            sh_q    <= xw_q.data;
            lhdr_q  <= xw_q.hdr;
            left_q  <= beats(lk_lv_q[2:1]);
            lk_st_q <= CTX_L_SEND;
          end
        end
        CTX_L_SEND: begin
          sh_q <= sh_q >> lane_bits(lk_lv_q[2:1]);
          if (left_q == 3'h0) begin
            lack_q  <= lreq_q;
            lk_st_q <= CTX_L_IDLE;
          end else begin
            left_q <= left_q - 3'h1;
          end
        end
        default: lk_st_q <= CTX_L_IDLE;
      endcase
    end
  end

  // Lane outputs from the serialiser; clock lane also driven by continuous mode
  always_ff @(posedge shared_tx_pll_ref_pin) begin
    if (lrst) begin
      lane_data_q  <= 32'h0000_0000;
      lane_hs_en_q <= 4'h0;
      lane_hdr_q   <= 1'b0;
      clk_hs_q     <= 1'b0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        lane_data_q[8*i +: 8] <= (lk_st_q == CTX_L_SEND && lk_mask[i]) ?
                                 sh_q[8*i +: 8] : 8'h00;
      end
      lane_hs_en_q <= (lk_st_q == CTX_L_SEND) ?
                      lk_mask & ~lk_lv_q[7:4] : 4'h0;
      lane_hdr_q   <= (lk_st_q == CTX_L_SEND) & lhdr_q;
      clk_hs_q     <= ~lk_lv_q[8] & (lk_lv_q[3] | lk_new | lk_st_q == CTX_L_SEND);
    end
  end

  assign lane_data      = lane_data_q;
  assign lane_hs_en     = lane_hs_en_q;
  assign lane_hdr       = lane_hdr_q;
  assign clk_lane_hs    = clk_hs_q;
  assign lane_sleep     = lk_lv_q[7:4];
  assign clk_lane_sleep = lk_lv_q[8];

  // ---------------- Assertions ----------------
  sequence s_frame_start;
    $rose(vsync);
  endsequence
  sequence s_line_start;
    $rose(hsync);
  endsequence

  property p_lanes_hold;
    @(posedge mclk) disable iff (rst) !ctrl_rst |=> $stable(lanes_q) && $stable(fm_q);
  endproperty
  a_lanes_hold: assert property (p_lanes_hold) else $error("lane select moved out of reset");

  property p_frame_mode;
    @(posedge mclk) disable iff (rst) ctrl_rst ##1 ctrl_rst |-> fm_q == $past(frame_mode);
  endproperty
  a_frame_mode: assert property (p_frame_mode) else $error("frame mode not latched");

  property p_frame_cap;
    @(posedge mclk) disable iff (ctrl_rst)
      s_frame_start |-> ##1 width_q == $past(line_width) && vc_q == $past(virtual_channel);
  endproperty
  a_frame_cap: assert property (p_frame_cap) else $error("frame fields not captured");

  property p_line_cap;
    @(posedge mclk) disable iff (ctrl_rst) s_line_start |=> dt_q == $past(data_type);
  endproperty
  a_line_cap: assert property (p_line_cap) else $error("data type not captured");

  property p_clk_sleep;
    @(posedge mclk) disable iff (ctrl_rst)
      $rose(sleep_q[4]) |-> $past(en_cnt_q[4]) == 10'(SLEEP_CYC - 1) && $past(sl_en[4]);
  endproperty
  a_clk_sleep: assert property (p_clk_sleep) else $error("clock lane slept early");

  property p_data_sleep;
    @(posedge mclk) disable iff (ctrl_rst)
      $fell(sleep_q[0]) |-> $past(ex_cnt_q[0]) == 10'(SLEEP_CYC - 1) && $past(sl_ex[0]);
  endproperty
  a_data_sleep: assert property (p_data_sleep) else $error("data lane woke early");

  property p_conflict;
    @(posedge mclk) disable iff (ctrl_rst)
      sl_en[4] && sl_ex[4] |=> $stable(sleep_q[4]) && st_q[`CTX_ST_CONFL_BIT];
  endproperty
  a_conflict: assert property (p_conflict) else $error("conflicting sleep not ignored");

  property p_payload;
    @(posedge mclk) disable iff (ctrl_rst)
      launch && !nw.hdr |-> pix_valid ##1 xw_q.data == $past(pixel_data);
  endproperty
  a_payload: assert property (p_payload) else $error("payload without valid");

  property p_lane_mask;
    @(posedge shared_tx_pll_ref_pin) disable iff (lrst)
      (lane_hs_en & ~lane_mask(lk_lv_q[2:1])) == 4'h0;
  endproperty
  a_lane_mask: assert property (p_lane_mask) else $error("disabled lane active");

  property p_phy_rst;
    @(posedge shared_tx_pll_ref_pin) disable iff (lk_lv_q[0])
      lrst |=> lane_hs_en == 4'h0 && !clk_lane_hs;
  endproperty
  a_phy_rst: assert property (p_phy_rst) else $error("lanes active in reset");

  property p_cont_clk;
    @(posedge shared_tx_pll_ref_pin) disable iff (lrst)
      lk_lv_q[3] && !lk_lv_q[8] |=> clk_lane_hs;
  endproperty
  a_cont_clk: assert property (p_cont_clk) else $error("continuous clock dropped");

endmodule : ctx_pixel_if

`default_nettype wire

// ==== verification/ctx_rx_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// Board receiver: gathers lane bytes back into 64-bit words
module ctx_rx_model (
  input  wire logic        shared_tx_pll_ref_pin,
  input  wire logic [31:0] lane_data,
  input  wire logic [3:0]  lane_hs_en,
  input  wire logic        lane_hdr,
  output logic             rx_stb,
  output logic [63:0]      rx_word,
  output logic             rx_hdr
);
  logic [63:0] acc_q;    // Bytes gathered so far
  int          nb_q = 0; // Count of gathered bytes
  // Lower lanes carry the earlier bytes of each beat
  always @(posedge shared_tx_pll_ref_pin) begin
    rx_stb <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      if (lane_hs_en[i]) begin
        acc_q[8*nb_q +: 8] = lane_data[8*i +: 8];
        nb_q = nb_q + 1;
      end
    end
    // A full word is handed on with its header flag
    if (nb_q == 8) begin
      rx_word <= acc_q;
      rx_hdr  <= lane_hdr;
      rx_stb  <= 1'b1;
      nb_q = 0;
    end
  end
endmodule : ctx_rx_model
`default_nettype wire

// ==== verification/testbench.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "ctx_defs.svh"
module testbench;
  logic mclk = 0, shared_tx_pll_ref_pin = 0, rst = 1, phy_reset_n = 0, controller_reset_n = 0;
  logic [1:0] lane_select = 2'h3, virtual_channel = 2'h0, vc;
  logic frame_mode = 0, vsync = 0, hsync = 0, pix_valid = 0, clock_lane_sleep_enter = 0;
  logic clock_lane_sleep_exit = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid, lane_hdr, clk_lane_hs, clk_lane_sleep, rx_stb, rx_hdr;
  logic [15:0] line_width = 16'h0, w;
  logic [5:0]  data_type = 6'h2A;
  logic [63:0] pixel_data = 64'h0, rx_word, d;
  logic [3:0]  data_lane_sleep_enter = 0, data_lane_sleep_exit = 0, s_axi_wstrb = 4'hF;
  logic [3:0]  lane_hs_en, lane_sleep;
  logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, lane_data;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [33:0] r;
  logic [64:0] expq[$], mskq[$];
  int          bad_count = 0, num_checks = 0, seed = 84;
  logic        escape_clock = 0;
  ctx_pixel_if i_dut (.*);
  ctx_rx_model i_rx (.*);
  // Pixel clock, link clock free running at an unrelated phase
  always #5 mclk = ~mclk;
  always #25 escape_clock = ~escape_clock;
  initial begin
    #7;
    forever #32 shared_tx_pll_ref_pin = ~shared_tx_pll_ref_pin;
  end
  task chk(input logic [64:0] got, input logic [64:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task tally_and_finish;
    $display("checks=%0d mismatches=%0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : tally_and_finish
  // Each received word against the oldest expected one
  always @(posedge shared_tx_pll_ref_pin) begin
    if (rx_stb === 1'b1 && expq.size() == 0) chk({rx_hdr, rx_word}, 'x);
    else if (rx_stb === 1'b1) chk({rx_hdr, rx_word} & mskq.pop_front(), expq.pop_front());
  end
  // Bus tasks sample ready and response at the rising edge, then idle one edge
  task wr(input logic [7:0] a, input logic [31:0] dat);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= dat;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    @(posedge mclk);
  endtask : wr
  task rd(input logic [7:0] a);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      r = {s_axi_rresp, s_axi_rdata};
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    @(posedge mclk);
  endtask : rd
  // Sync levels plus a one-cycle pixel, then room for the link
  task step(input logic [2:0] vhp, input logic [63:0] dat, input logic h, input logic [63:0] m);
    if (h) expq.push_back({1'b1, dat});
    if (h) mskq.push_back({1'b1, m});
    {vsync, hsync, pix_valid} <= vhp;
    pixel_data <= dat;
    @(posedge mclk);
    pix_valid <= 1'b0;
    pixel_data <= ~dat;
    repeat (150) @(posedge mclk);
  endtask : step
  task sleep(input logic [4:0] en, input logic [4:0] ex, input int n);
    {clock_lane_sleep_enter, data_lane_sleep_enter} <= en;
    {clock_lane_sleep_exit, data_lane_sleep_exit} <= ex;
    repeat (n) @(posedge mclk);
    {clock_lane_sleep_enter, data_lane_sleep_enter, clock_lane_sleep_exit} <= 6'h0;
    data_lane_sleep_exit <= 4'h0;
    repeat (40) @(posedge mclk);
  endtask : sleep
  initial begin
    #200000;
    bad_count++;
    tally_and_finish();
  end
  initial begin
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    repeat (120) @(posedge mclk);
    {phy_reset_n, controller_reset_n} <= 2'h3;
    repeat (20) @(posedge mclk);
    rd(`CTX_REG_CTRL);
    chk(r, {`CTX_RESP_OKAY, 30'h0, `CTX_CTRL_RST});
    rd(`CTX_REG_CFG);
    chk(r[2:0], 3'h3);
    rd(8'h40);
    chk(r, {`CTX_RESP_DECERR, 32'h0});
    {vc, w, d} = 82'({$random(seed), $random(seed), $random(seed), $random(seed)});
    {virtual_channel, line_width} <= {vc, w};
    repeat (2) @(posedge mclk);
    step(3'h4, {40'h0, vc, `CTX_DT_FS, 16'h0}, 1, 64'hFF_0000);
    step(3'h6, {40'h0, vc, 6'h2A, w}, 1, 64'hFF_FFFF);
    expq.push_back({1'b0, d});
    mskq.push_back('1);
    step(3'h7, d, 0, 0);
    step(3'h4, d, 0, 0);
    data_type <= 6'h3F;
    step(3'h4, 0, 0, 0);
    step(3'h6, {40'h0, vc, 6'h3F, w}, 1, 64'hFF_FFFF);
    step(3'h4, 0, 0, 0);
    step(3'h0, {40'h0, vc, `CTX_DT_FE, 16'h0}, 1, 64'hFF_0000);
    chk(expq.size(), 0);
    rd(`CTX_REG_STATUS);
    chk(r[0], 1'b1);
    wr(`CTX_REG_STATUS, 32'h1);
    rd(`CTX_REG_STATUS);
    chk(r[0], 1'b0);
    chk(clk_lane_hs, 1'b0);
    wr(`CTX_REG_CTRL, 32'h3);
    repeat (40) @(posedge mclk);
    chk(clk_lane_hs, 1'b1);
    rd(`CTX_REG_WIDTH);
    chk(r[15:0], w);
    $display("frame test done");
    sleep(5'h11, 5'h0, 500);
    chk({clk_lane_hs, clk_lane_sleep, lane_sleep}, 6'h11);
    sleep(5'h12, 5'h12, 8);
    rd(`CTX_REG_STATUS);
    chk(r[12:0] & 13'h1F04, 13'h1104);
    sleep(5'h0, 5'h11, 500);
    chk({clk_lane_hs, clk_lane_sleep, lane_sleep}, 6'h20);
    $display("sleep test done");
    // Controller reset alone re-latches the lane count
    controller_reset_n <= 1'b0;
    repeat (10) @(posedge mclk);
    lane_select <= 2'h1;
    repeat (10) @(posedge mclk);
    controller_reset_n <= 1'b1;
    repeat (60) @(posedge mclk);
    rd(`CTX_REG_CFG);
    chk(r[1:0], 2'h1);
    d = {$random(seed), $random(seed)};
    expq.push_back({1'b0, d});
    mskq.push_back('1);
    step(3'h1, d, 0, 0);
    chk(expq.size(), 0);
    $display("lane test done");
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
